// file: twm_pkg.sv
// Package of constants and types for the two-wire master transmitter
// Operation
// - In master role the block starts every transfer, drives the serial clock and ends the transfer.
// - The target address may change while master role stays enabled.
// - A holding register write while idle issues START and then the 7-bit target address.
// - The bit after the address gives the direction, 0 for a write when read select is clear.
// - On the 9th clock pulse the master releases the data line and the target pulls it low to acknowledge.
// - A byte not acknowledged sets the not-acknowledge flag and then a STOP is sent.
// - Each status flag raises the interrupt output only when its enable bit is set.
// - After an acknowledge the holding register byte moves to the shifter and is sent.
// - An acknowledge sets the transmit-ready flag, which stays set until the next holding register write.
// - The transmit-ready flag is also the transmit request of the peripheral DMA channel.
// - While no new byte is written the serial clock is held low.
// - A new holding register write releases the clock and the byte is sent.
// - Writing 1 to the stop command generates a STOP condition.
// - Writing 1 to an interrupt enable bit enables that source, writing 0 leaves it unchanged.
package twm_pkg;

    // ==========================================================
    // Status bit positions and reset values
    localparam int unsigned TWM_ST_TXCOMP = 0;
    localparam int unsigned TWM_ST_TRANSMIT_READY_FLAG  = 1;
    localparam int unsigned TWM_ST_NACK   = 2;
    localparam logic [2:0]  TWM_IER_RST   = 3'h0;
    localparam logic        TWM_TRANSMIT_READY_FLAG_RST = 1'h0;

    // ==========================================================
    // Timing
    localparam logic [15:0] TWM_HALF_MIN  = 16'h0001;

    typedef struct packed {
        logic       nack;
        logic       transmit_ready_flag;
        logic       txcomp;
    } twm_status_t;

    typedef struct packed {
        logic [6:0] target_device_address;
        logic       read_direction_select;
        logic [2:0] clock_divider_exponent;
        logic [7:0] clock_high_divider;
        logic [7:0] clock_low_divider;
    } twm_cfg_t;

    typedef enum logic [3:0] {
        TWM_IDLE  = 4'h0,
        TWM_START = 4'h1,
        TWM_BLOW  = 4'h2,
        TWM_BHIGH = 4'h3,
        TWM_ALOW  = 4'h4,
        TWM_AHIGH = 4'h5,
        TWM_HOLD  = 4'h6,
        TWM_SLOW  = 4'h7,
        TWM_SHIGH = 4'h8,
        TWM_SFREE = 4'h9
    } twm_state_t;

    // Half period in system clocks: (div + 1) << exponent
    function automatic logic [15:0] twm_half_len(input logic [7:0] div, input logic [2:0] ex);
        logic [15:0] base;
        base = 16'({8'h00, div}) + TWM_HALF_MIN;
        return 16'(base << ex);
    endfunction

endpackage

// file: twm_sync2.sv
// Two-flop synchroniser for bus line inputs
`timescale 1ns/1ps
`default_nettype none
module twm_sync2 #(
    parameter int unsigned W = 2
) (
    // Clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_rstn,
    // Data
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;

    // Reset to released (high) lines
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            meta_q <= '1;
            o_sync <= '1;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule // twm_sync2
`default_nettype wire

// file: twm_master_tx.sv
// Two-wire master transmitter: byte engine, flags and bus pin drive
`timescale 1ns/1ps
`default_nettype none
module twm_master_tx (
    // Clock and reset
    input  wire logic               i_clk_sys,
    input  wire logic               i_rstn,
    // Control
    input  wire logic               i_master_role_enable,
    input  wire logic               i_target_role_disable,
    input  wire twm_pkg::twm_cfg_t  i_cfg,
    input  wire logic               i_stop_cmd,
    // Holding register write
    input  wire logic               i_thr_wr,
    input  wire logic [7:0]         i_thr_data,
    // Status and interrupt
    input  wire logic               i_status_rd,
    input  wire logic               i_ier_wr,
    input  wire twm_pkg::twm_status_t i_ier_data,
    output twm_pkg::twm_status_t    o_status,
    output logic [2:0]              o_ier,
    output logic                    o_irq,
    output logic                    o_dma_tx_req,
    // Bus pins, open drain
    input  wire logic               i_scl_in,
    output logic                    o_scl_out,
    output logic                    o_scl_oe_n,
    input  wire logic               i_sda_in,
    output logic                    o_sda_out,
    output logic                    o_sda_oe_n
);
    import twm_pkg::*;

    // ==========================================================
    // Input synchronisation
    logic [1:0] lines_s;
    logic       scl_s;
    logic       sda_s;

    twm_sync2 #(.W(2)) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_async   ({i_scl_in, i_sda_in}),
        .o_sync    (lines_s)
    );
    assign scl_s = lines_s[1];
    assign sda_s = lines_s[0];

    // ==========================================================
    // State
    twm_state_t  state_q, state_d;
    logic [15:0] cnt_q;
    logic [7:0]  sh_q;
    logic [7:0]  thr_q;
    logic        thr_full_q;
    logic [2:0]  bit_q;
    logic        stop_q;
    logic        transmit_ready_flag_q;
    logic        nack_q;
    logic        txcomp_q;
    logic [2:0]  ier_q;
    logic        scl_rel_q;
    logic        sda_rel_q;

    // ==========================================================
    // Decode
    wire         master_on  = i_master_role_enable & i_target_role_disable;
    wire [15:0]  low_len    = twm_half_len(i_cfg.clock_low_divider, i_cfg.clock_divider_exponent);
    wire [15:0]  high_len   = twm_half_len(i_cfg.clock_high_divider, i_cfg.clock_divider_exponent);
    wire         high_phase = (state_q == TWM_START) || (state_q == TWM_BHIGH) ||
                              (state_q == TWM_AHIGH) || (state_q == TWM_SHIGH) || (state_q == TWM_SFREE);
    // High phase ends only once the line is seen high, so a target may stretch
    wire         half_done  = high_phase ? (scl_s && cnt_q >= high_len) : (cnt_q >= low_len);
    wire         ack_end    = (state_q == TWM_AHIGH) && half_done;
    wire         ack_ok     = ack_end && !sda_s;
    wire         ack_bad    = ack_end && sda_s;
    wire         go_start   = (state_q == TWM_IDLE) && i_thr_wr && master_on;
    wire         load_ack   = ack_ok && thr_full_q;
    wire         load_hold  = (state_q == TWM_HOLD) && thr_full_q;
    wire         load_sh    = load_ack || load_hold;
    wire         stop_done  = (state_q == TWM_SFREE) && half_done;

    // ==========================================================
    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            TWM_IDLE:  if (go_start) state_d = TWM_START;
            TWM_START: if (half_done) state_d = TWM_BLOW;
            TWM_BLOW:  if (half_done) state_d = TWM_BHIGH;
            TWM_BHIGH: if (half_done) state_d = (bit_q == 3'h7) ? TWM_ALOW : TWM_BLOW;
            TWM_ALOW:  if (half_done) state_d = TWM_AHIGH;
            TWM_AHIGH: begin
                if (ack_bad) state_d = TWM_SLOW;
                else if (load_ack) state_d = TWM_BLOW;
                else if (ack_ok) state_d = stop_q ? TWM_SLOW : TWM_HOLD;
            end
            TWM_HOLD: begin
                if (load_hold) state_d = TWM_BLOW;
                else if (stop_q) state_d = TWM_SLOW;
            end
            TWM_SLOW:  if (half_done) state_d = TWM_SHIGH;
            TWM_SHIGH: if (half_done) state_d = TWM_SFREE;
            TWM_SFREE: if (half_done) state_d = TWM_IDLE;
            default:   state_d = TWM_IDLE;
        endcase
    end

    // ==========================================================
    // Engine
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            state_q <= TWM_IDLE;
            cnt_q   <= 16'h0000;
            sh_q    <= 8'h00;
            bit_q   <= 3'h0;
        end else begin
            state_q <= state_d;
            cnt_q   <= (state_d != state_q) ? 16'h0001 : cnt_q + 16'h0001;
            if (go_start) begin
                // Address sampled at start, so it may change between transfers
                sh_q  <= {i_cfg.target_device_address, i_cfg.read_direction_select};
                bit_q <= 3'h0;
            end else if (load_sh) begin
                sh_q  <= thr_q;
                bit_q <= 3'h0;
            end else if (state_q == TWM_BHIGH && half_done) begin
                sh_q  <= {sh_q[6:0], 1'b0};
                bit_q <= bit_q + 3'h1;
            end
        end
    end

    // Holding register and stop request
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            thr_q      <= 8'h00;
            thr_full_q <= 1'b0;
            stop_q     <= 1'b0;
        end else begin
            if (i_thr_wr) thr_q <= i_thr_data;
            // A write in the load cycle refills the register
            // The starting write's byte is the first data byte after the address
            thr_full_q <= i_thr_wr || (thr_full_q && !load_sh);
            // Idle drops a request that arrived as the stop ended
            stop_q     <= (i_stop_cmd && state_q != TWM_IDLE) || (stop_q && !stop_done && state_q != TWM_IDLE);
        end
    end

    // Flags: a set in the clearing cycle wins
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            transmit_ready_flag_q  <= TWM_TRANSMIT_READY_FLAG_RST;
            nack_q   <= 1'b0;
            txcomp_q <= 1'b0;
            ier_q    <= TWM_IER_RST;
        end else begin
            transmit_ready_flag_q  <= ack_ok || (transmit_ready_flag_q && !i_thr_wr);
            nack_q   <= ack_bad || (nack_q && !i_status_rd);
            txcomp_q <= stop_done || (txcomp_q && !go_start);
            if (i_ier_wr) ier_q <= ier_q | i_ier_data;
        end
    end

    // ==========================================================
    // Pin drive, registered to avoid glitches on the bus
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            scl_rel_q <= 1'b1;
            sda_rel_q <= 1'b1;
        end else begin
            // Master owns the clock; low phases and hold keep it low
            scl_rel_q <= (state_d == TWM_IDLE) || (state_d == TWM_START) || (state_d == TWM_BHIGH) ||
                         (state_d == TWM_AHIGH) || (state_d == TWM_SHIGH) || (state_d == TWM_SFREE);
            // Data trails the state by one cycle, so it never moves as the clock falls
            sda_rel_q <= (state_q == TWM_IDLE) || (state_q == TWM_ALOW) || (state_q == TWM_AHIGH) ||
                         (state_q == TWM_HOLD) || (state_q == TWM_SFREE) ||
                         (((state_q == TWM_BLOW) || (state_q == TWM_BHIGH)) && sh_q[7]);
        end
    end

    // ==========================================================
    // Outputs
    assign o_status     = '{nack: nack_q, transmit_ready_flag: transmit_ready_flag_q, txcomp: txcomp_q};
    assign o_ier        = ier_q;
    assign o_irq        = |(o_status & ier_q);
    assign o_dma_tx_req = transmit_ready_flag_q;
    assign o_scl_out    = 1'b0;
    assign o_scl_oe_n   = scl_rel_q;
    assign o_sda_out    = 1'b0;
    assign o_sda_oe_n   = sda_rel_q;

endmodule // twm_master_tx
`default_nettype wire

// file: twm_master_tx_props.sv
// Port-level assertions for the two-wire master transmitter
`timescale 1ns/1ps
`default_nettype none
module twm_master_tx_props (
    // Clock and reset
    input wire logic                 i_clk_sys,
    input wire logic                 i_rstn,
    // Requests
    input wire logic                 i_thr_wr,
    input wire logic                 i_stop_cmd,
    input wire logic                 i_status_rd,
    input wire logic                 i_ier_wr,
    input wire twm_pkg::twm_status_t i_ier_data,
    // Outputs
    input wire twm_pkg::twm_status_t o_status,
    input wire logic [2:0]           o_ier,
    input wire logic                 o_irq,
    input wire logic                 o_dma_tx_req,
    input wire logic                 o_scl_oe_n,
    input wire logic                 o_sda_oe_n
);
    import twm_pkg::*;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    // ==========================================================
    // Bus conditions
    sequence stop_seq;
        o_scl_oe_n && $rose(o_sda_oe_n);
    endsequence
    sequence start_seq;
        o_scl_oe_n && $fell(o_sda_oe_n);
    endsequence
    // ==========================================================
    // Checks
    a_irq_mask: assert property (o_irq == |(o_status & o_ier)) else $error("irq not status and enable");
    a_dma_ready: assert property (o_dma_tx_req == o_status.transmit_ready_flag) else $error("dma request off ready");
    a_ier_set: assert property (i_ier_wr |=> o_ier == ($past(o_ier) | $past(i_ier_data)))
        else $error("enable write wrong");
    a_ier_keep: assert property (!i_ier_wr |=> $stable(o_ier)) else $error("enable changed unasked");
    a_ready_hold: assert property (o_status.transmit_ready_flag && !i_thr_wr |=> o_status.transmit_ready_flag)
        else $error("ready dropped without write");
    a_start_cause: assert property (start_seq |-> $past(i_thr_wr) || $past(i_thr_wr, 2) || $past(i_thr_wr, 3))
        else $error("start without write");
    a_nack_stop: assert property ($rose(o_status.nack) |-> ##[1:300] stop_seq) else $error("no stop after nack");
    a_stop_cmd: assert property (i_stop_cmd && o_status.transmit_ready_flag && !o_status.txcomp |-> ##[1:400] stop_seq)
        else $error("stop command lost");
    a_stop_idle: assert property (stop_seq |-> ##[1:40] o_status.txcomp) else $error("no idle after stop");
    a_nack_clear: assert property (i_status_rd && o_status.txcomp |=> !o_status.nack)
        else $error("status read kept nack");
endmodule // twm_master_tx_props
bind twm_master_tx twm_master_tx_props u_props (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_thr_wr(i_thr_wr),
    .i_stop_cmd(i_stop_cmd), .i_status_rd(i_status_rd), .i_ier_wr(i_ier_wr), .i_ier_data(i_ier_data),
    .o_status(o_status), .o_ier(o_ier), .o_irq(o_irq), .o_dma_tx_req(o_dma_tx_req),
    .o_scl_oe_n(o_scl_oe_n), .o_sda_oe_n(o_sda_oe_n));
`default_nettype wire

// file: twm_target_model.sv
// Behavioural write target on the shared two-wire bus
`timescale 1ns/1ps
`default_nettype none
module twm_target_model (
    // Wire levels
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    // High: refuse every byte
    input  wire logic       i_refuse,
    output logic            o_sda_oe_n,
    output logic [3:0][7:0] o_rx,
    output logic [7:0]      o_count
);
    logic       active;
    logic [3:0] bits;
    logic [7:0] shift;
    initial begin
        {active, bits, shift, o_rx, o_count} = '0;
        o_sda_oe_n = 1'b1;
    end
    always @(negedge i_sda) if (i_scl) {active, bits} = 5'h10;
    always @(posedge i_sda) if (i_scl) active = 1'b0;
    always @(posedge i_scl) if (active && bits < 8) begin
        shift = {shift[6:0], i_sda};
        bits = bits + 4'h1;
    end
    // Ninth pulse: pull low to acknowledge, release after it
    always @(negedge i_scl) if (active) begin
        if (bits == 8) begin
            o_rx[o_count[1:0]] = shift;
            o_count = o_count + 8'h01;
            o_sda_oe_n = i_refuse;
            bits = 4'h9;
        end else if (bits == 9) begin
            o_sda_oe_n = 1'b1;
            bits = 4'h0;
        end
    end
endmodule // twm_target_model
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the two-wire master transmitter
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import twm_pkg::*;
    logic            i_clk_sys, i_rstn, i_thr_wr, i_stop_cmd, i_status_rd, i_ier_wr, refuse, men, tdis;
    logic [7:0]      i_thr_data, count;
    logic [2:0]      o_ier;
    logic [3:0][7:0] rx;
    logic            o_irq, o_dma_tx_req, scl_oe_n, sda_oe_n, tgt_oe_n, scl_out, sda_out;
    twm_cfg_t        i_cfg;
    twm_status_t     i_ier_data, o_status;
    int              mismatches, checks;
    // Open-drain lines with pull-ups
    wire logic scl = scl_oe_n ? 1'b1 : scl_out;
    wire logic sda = (sda_oe_n ? 1'b1 : sda_out) & tgt_oe_n;
    twm_master_tx dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_master_role_enable(men),
        .i_target_role_disable(tdis), .i_cfg(i_cfg), .i_stop_cmd(i_stop_cmd), .i_thr_wr(i_thr_wr),
        .i_thr_data(i_thr_data), .i_status_rd(i_status_rd), .i_ier_wr(i_ier_wr), .i_ier_data(i_ier_data),
        .o_status(o_status), .o_ier(o_ier), .o_irq(o_irq), .o_dma_tx_req(o_dma_tx_req), .i_scl_in(scl),
        .o_scl_out(scl_out), .o_scl_oe_n(scl_oe_n), .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n));
    twm_target_model tgt (.i_scl(scl), .i_sda(sda), .i_refuse(refuse), .o_sda_oe_n(tgt_oe_n), .o_rx(rx),
        .o_count(count));
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // 0 holding write, 1 stop, 2 status read, 3 enable write
    task automatic pulse(input int k, input logic [7:0] d);
        @(posedge i_clk_sys);
        case (k)
            0: {i_thr_wr, i_thr_data} <= {1'b1, d};
            1: i_stop_cmd <= 1'b1;
            2: i_status_rd <= 1'b1;
            default: {i_ier_wr, i_ier_data} <= {1'b1, d[2:0]};
        endcase
        @(posedge i_clk_sys);
        {i_thr_wr, i_stop_cmd, i_status_rd, i_ier_wr} <= 4'h0;
        #1;
    endtask
    // Negative b: n bytes taken and acknowledge over; else status bit b
    task automatic wt(input int n, input int b);
        for (int i = 0; i < 4000; i++) begin
            @(posedge i_clk_sys);
            #1;
            if (b < 0 ? (count >= n && tgt_oe_n === 1'b1) : o_status[b] === 1'b1) return;
        end
        mismatches++;
        $display("mismatch at %0t: wait ran out", $time);
        summarize();
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_stream();
        chk({o_status, o_ier, o_irq, o_dma_tx_req}, 8'h00, "reset flags");
        chk({scl_oe_n, sda_oe_n}, 8'h03, "reset lines");
        chk({scl_out, sda_out}, 8'h00, "driven level low");
        pulse(3, 8'h02);
        chk(o_ier, 8'h02, "enable ready");
        pulse(0, 8'ha5);
        wt(2, -1);
        chk(rx[0], {7'h5a, 1'b0}, "address and write bit");
        chk(rx[1], 8'ha5, "first byte");
        repeat (50) @(posedge i_clk_sys);
        chk({o_status.transmit_ready_flag, o_dma_tx_req, o_irq, scl_oe_n}, 8'h0e, "ready and clock held");
        @(posedge i_clk_sys);
        i_cfg.target_device_address <= 7'h33;
        pulse(0, 8'h3c);
        @(posedge i_clk_sys);
        #1;
        chk(o_status.transmit_ready_flag, 8'h00, "ready cleared");
        wt(3, -1);
        chk(rx[2], 8'h3c, "byte after release");
        pulse(1, 8'h00);
        wt(0, TWM_ST_TXCOMP);
        chk({scl_oe_n, sda_oe_n}, 8'h03, "stop then idle");
    endtask
    task automatic t_nack();
        refuse <= 1'b1;
        pulse(3, 8'h04);
        chk(o_ier, 8'h06, "enable keeps bits");
        pulse(0, 8'h77);
        wt(0, TWM_ST_NACK);
        chk(rx[3], {7'h33, 1'b0}, "changed address");
        chk({o_irq, o_status.transmit_ready_flag}, 8'h02, "nack interrupt");
        wt(0, TWM_ST_TXCOMP);
        chk({scl_oe_n, sda_oe_n, o_status.nack}, 8'h07, "stop after nack");
        refuse <= 1'b0;
        pulse(2, 8'h00);
        chk({o_status.nack, o_irq}, 8'h00, "read clears nack");
    endtask
    task automatic t_off();
        @(posedge i_clk_sys);
        men <= 1'b0;
        pulse(0, 8'h11);
        repeat (20) @(posedge i_clk_sys);
        #1;
        chk({scl_oe_n, sda_oe_n, o_status.txcomp}, 8'h07, "no start while disabled");
        chk(count, 8'h04, "no byte while disabled");
    endtask
    initial begin
        {i_rstn, i_thr_wr, i_stop_cmd, i_status_rd, i_ier_wr, refuse} = '0;
        {men, tdis} = 2'h3;
        i_thr_data = 8'h00;
        i_ier_data = '0;
        i_cfg = {7'h5a, 1'b0, 3'h0, 8'h07, 8'h07};
        mismatches = 0;
        checks = 0;
        repeat (20) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        @(posedge i_clk_sys);
        #1;
        t_stream();
        t_nack();
        t_off();
        summarize();
    end
endmodule // testbench
`default_nettype wire
